// file: fcc_core.sv
/*
 Control logic of a photo-flash capacitor charger: charge enable latch,
 primary switch sequencing, completion flag and flash gate drive.
 Assumes comparator events arrive as logic levels from analog front ends.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcc_consts.svh"
module fcc_core #(
  parameter int START_CYC = `FCC_START_CYC,
  parameter int GATE_CYC = `FCC_GATE_CYC,
  parameter int FULL_CYC = `FCC_FULL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic charge_request,
  input wire logic flash_trigger,
  input wire logic peak_select_high,
  input wire logic peak_select_analog,
  input wire logic over_peak_low_threshold,
  input wire logic over_peak_high_threshold,
  input wire logic over_peak_analog,
  input wire logic zero_comparator,
  input wire logic full_comparator,
  input wire logic switch_overvoltage_fault,
  output logic primary_switch,
  output logic gate_drive_out,
  output logic complete_flag_n_out,
  output logic complete_flag_n_oe,
  output logic charge_enable_latch
);
  import fcc_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [7:0] raw;
  logic [7:0] syn;
  logic req_s;
  logic trig_s;
  logic cur_s;
  logic zero_s;
  logic full_s;
  logic ov_s;

  assign raw = {flash_trigger, charge_request, over_peak_low_threshold,
                over_peak_high_threshold, over_peak_analog, zero_comparator,
                full_comparator, switch_overvoltage_fault};

  fcc_sync #(.W(8)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(raw),
    .q(syn)
  );

  assign trig_s = syn[7];
  assign req_s = syn[6];
  assign zero_s = syn[2];
  assign full_s = syn[1];
  assign ov_s = syn[0];

  // Peak-current event from the selected threshold comparator.
  always_comb begin
    if (peak_select_analog) begin
      cur_s = syn[3];
    end else if (peak_select_high) begin
      cur_s = syn[4];
    end else begin
      cur_s = syn[5];
    end
  end

  // ****************************************************************
  // Charge sequencing
  // ****************************************************************
  fcc_state_t state_reg;
  fcc_state_t state_next;
  logic req_d_reg;
  logic req_d_next;
  logic en_next;
  logic switch_next;
  logic fault_reg;
  logic fault_next;
  logic done_reg;
  logic done_next;
  logic [`FCC_CNT_W-1:0] cnt_reg;
  logic [`FCC_CNT_W-1:0] cnt_next;
  logic rise;

  assign rise = req_s && !req_d_reg;

  always_comb begin
    state_next = state_reg;
    req_d_next = req_s;
    en_next = charge_enable_latch;
    fault_next = fault_reg;
    done_next = done_reg;
    cnt_next = cnt_reg;
    if (rise) begin
      en_next = 1'b1;
      fault_next = 1'b0;
      done_next = 1'b0;
      state_next = FCC_START;
      cnt_next = `FCC_CNT_W'(START_CYC - 1);
    end else if (!req_s) begin
      en_next = 1'b0;
      state_next = FCC_IDLE;
      done_next = 1'b0;
      fault_next = 1'b0;
    end else if (charge_enable_latch && ov_s && state_reg == FCC_ON) begin
      en_next = 1'b0;
      fault_next = 1'b1;
      state_next = FCC_IDLE;
    end else if (charge_enable_latch && full_s && state_reg == FCC_OFF) begin
      en_next = 1'b0;
      done_next = 1'b1;
      state_next = FCC_IDLE;
      cnt_next = `FCC_CNT_W'(FULL_CYC - 1);
    end else begin
      case (state_reg)
        FCC_IDLE: begin
          if (done_reg && cnt_reg != `FCC_ZERO_CNT) begin
            cnt_next = cnt_reg - `FCC_ONE_CNT;
          end
        end
        FCC_START: begin
          if (cnt_reg == `FCC_ZERO_CNT) begin
            state_next = FCC_ON;
          end else begin
            cnt_next = cnt_reg - `FCC_ONE_CNT;
          end
        end
        FCC_ON: begin
          if (cur_s) begin
            state_next = FCC_OFF;
          end
        end
        FCC_OFF: begin
          if (zero_s) begin
            state_next = FCC_ON;
          end
        end
        default: state_next = FCC_IDLE;
      endcase
    end
    switch_next = (state_next == FCC_ON) && req_s;
    if (!ce) begin
      state_next = state_reg;
      req_d_next = req_d_reg;
      en_next = charge_enable_latch;
      fault_next = fault_reg;
      done_next = done_reg;
      cnt_next = cnt_reg;
      switch_next = primary_switch;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= FCC_IDLE;
      req_d_reg <= 1'b0;
      charge_enable_latch <= 1'b0;
      fault_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= `FCC_ZERO_CNT;
      primary_switch <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_d_reg <= req_d_next;
      charge_enable_latch <= en_next;
      fault_reg <= fault_next;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
      primary_switch <= switch_next;
    end
  end

  // ****************************************************************
  // Completion flag and flash gate drive
  // ****************************************************************
  logic flag_oe_next;
  logic gate_next;
  logic [`FCC_CNT_W-1:0] gcnt_reg;
  logic [`FCC_CNT_W-1:0] gcnt_next;
  logic gate_want;

  assign gate_want = trig_s && !req_s;

  always_comb begin
    flag_oe_next = done_next && !fault_next &&
                   state_reg == FCC_IDLE && cnt_reg == `FCC_ZERO_CNT;
    gate_next = gate_drive_out;
    gcnt_next = gcnt_reg;
    if (gate_want == gate_drive_out) begin
      gcnt_next = `FCC_CNT_W'(GATE_CYC - 1);
    end else if (gcnt_reg == `FCC_ZERO_CNT) begin
      gate_next = gate_want;
      gcnt_next = `FCC_CNT_W'(GATE_CYC - 1);
    end else begin
      gcnt_next = gcnt_reg - `FCC_ONE_CNT;
    end
    if (!ce) begin
      flag_oe_next = complete_flag_n_oe;
      gate_next = gate_drive_out;
      gcnt_next = gcnt_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      complete_flag_n_oe <= 1'b0;
      complete_flag_n_out <= 1'b0;
      gate_drive_out <= 1'b0;
      gcnt_reg <= `FCC_ZERO_CNT;
    end else begin
      complete_flag_n_oe <= flag_oe_next;
      complete_flag_n_out <= 1'b0;
      gate_drive_out <= gate_next;
      gcnt_reg <= gcnt_next;
    end
  end
endmodule
`default_nettype wire

// file: fcc_consts.svh
/*
 Timing and encoding constants of the flash charger control block.
 Assumes a 10 MHz clock; included by bare name.
*/
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH
`define FCC_CLK_MHZ 10
`define FCC_T_START_US 12
`define FCC_T_GATE_NS 50
`define FCC_T_FULL_NS 400
`define FCC_START_CYC ((`FCC_T_START_US * `FCC_CLK_MHZ) > 1 ? (`FCC_T_START_US * `FCC_CLK_MHZ) : 1)
`define FCC_NS_PER_US 1000
`define FCC_GATE_RAW ((`FCC_T_GATE_NS * `FCC_CLK_MHZ) / `FCC_NS_PER_US)
`define FCC_GATE_CYC (`FCC_GATE_RAW > 1 ? `FCC_GATE_RAW : 1)
`define FCC_FULL_RAW ((`FCC_T_FULL_NS * `FCC_CLK_MHZ) / `FCC_NS_PER_US)
`define FCC_FULL_CYC (`FCC_FULL_RAW > 1 ? `FCC_FULL_RAW : 1)
`define FCC_CNT_W 8
`define FCC_ZERO_CNT 8'h00
`define FCC_ONE_CNT 8'h01
`endif

// file: fcc_pkg.sv
/*
 Types of the flash charger control block.
 Assumes nothing of its surroundings.
*/
package fcc_pkg;
  typedef enum logic [1:0] {
    FCC_IDLE = 2'b00,
    FCC_START = 2'b01,
    FCC_ON = 2'b11,
    FCC_OFF = 2'b10
  } fcc_state_t;
endpackage

// file: fcc_sync.sv
/*
 Two-flop synchroniser for a vector of inputs.
 Assumes the inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fcc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s1_next;
  logic [W-1:0] q_next;

  always_comb begin
    s1_next = ce ? d : s1_reg;
    q_next = ce ? s1_reg : q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= s1_next;
      q <= q_next;
    end
  end
endmodule
`default_nettype wire

// file: fcc_chk_sva.sv
/* Port checker of fcc_core, bound to every instance.
 Assumes ce is held high and the shortened start count. */
`timescale 1ns/1ps
`default_nettype none
module fcc_chk #(
  parameter int START_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic charge_request,
  input wire logic peak_select_high,
  input wire logic peak_select_analog,
  input wire logic over_peak_low_threshold,
  input wire logic primary_switch,
  input wire logic gate_drive_out,
  input wire logic complete_flag_n_out,
  input wire logic complete_flag_n_oe,
  input wire logic charge_enable_latch
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_req_start: assert property ($rose(charge_request) |-> ##3 charge_enable_latch)
    else $error("latch not set after request rise");
  a_start_delay: assert property ($rose(charge_enable_latch)
    |-> ##START_CYC primary_switch)
    else $error("switch start delay wrong");
  a_req_stop: assert property ($fell(charge_request)
    |-> ##3 !(primary_switch || charge_enable_latch))
    else $error("switch or latch on after request fall");
  a_flag_release: assert property ($fell(charge_request) |-> ##3 !complete_flag_n_oe)
    else $error("flag held after request fall");
  a_flag_idle: assert property (complete_flag_n_oe
    |-> !charge_enable_latch && !primary_switch)
    else $error("flag pulled while charging");
  a_flag_drain: assert property (complete_flag_n_oe |-> !complete_flag_n_out)
    else $error("flag drives high");
  a_peak_off: assert property (primary_switch && over_peak_low_threshold
    && !peak_select_high && !peak_select_analog |-> ##[1:3] !primary_switch)
    else $error("switch stays on above low peak");
  a_gate_block: assert property (charge_request [*6] |=> !gate_drive_out)
    else $error("gate driven while request high");
endmodule
bind fcc_core fcc_chk #(.START_CYC(START_CYC)) i_chk (.clk, .rst, .charge_request,
  .peak_select_high, .peak_select_analog, .over_peak_low_threshold, .primary_switch,
  .gate_drive_out, .complete_flag_n_out, .complete_flag_n_oe, .charge_enable_latch);
`default_nettype wire

// file: fcc_host.sv
/* Host controller model driving charge request and flash trigger.
 Assumes the completion flag line has a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module fcc_host #(
  parameter int TMO = 60
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic trig,
  input wire logic flag_n,
  output logic charge_request,
  output logic flash_trigger
);
  logic [7:0] cnt_reg;
  logic quit_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      quit_reg <= 1'b0;
      charge_request <= 1'b0;
      flash_trigger <= 1'b0;
    end else begin
      cnt_reg <= (charge_request && flag_n) ? cnt_reg + 8'h01 : 8'h00;
      quit_reg <= go && (quit_reg || cnt_reg == 8'(TMO));
      charge_request <= go && !quit_reg;
      flash_trigger <= trig;
    end
  end
endmodule
`default_nettype wire

// file: flash_charger_control_tb.sv
/* Bench of fcc_core with a host model on the request side.
 Assumes the shortened start count and the default full and gate counts. */
`timescale 1ns/1ps
`default_nettype none
module flash_charger_control_tb;
  logic clk = 0, rst = 1, go = 0, trig = 0, psh = 0, psa = 0;
  logic lo = 0, hi = 0, an = 0, zero = 0, full = 0, ov = 0, ce = 1;
  logic charge_request, flash_trigger, primary_switch, gate_drive_out;
  logic flag_out, flag_oe, charge_enable_latch;
  wire logic flag_n = flag_oe ? flag_out : 1'b1;
  int errors = 0, comparisons = 0;
  logic [5:0] rows [5] = '{6'h08, 6'h29, 6'h2C, 6'h19, 6'h12};
  logic [2:0] gates [4] = '{3'h3, 3'h6, 3'h3, 3'h0};
  fcc_core #(.START_CYC(4), .GATE_CYC(1), .FULL_CYC(4)) i_dut (.clk(clk), .rst(rst),
    .ce(ce), .charge_request(charge_request), .flash_trigger(flash_trigger),
    .peak_select_high(psh), .peak_select_analog(psa), .over_peak_low_threshold(lo),
    .over_peak_high_threshold(hi), .over_peak_analog(an), .zero_comparator(zero),
    .full_comparator(full), .switch_overvoltage_fault(ov), .primary_switch(primary_switch),
    .gate_drive_out(gate_drive_out), .complete_flag_n_out(flag_out),
    .complete_flag_n_oe(flag_oe), .charge_enable_latch(charge_enable_latch));
  fcc_host #(.TMO(60)) i_host (.clk(clk), .rst(rst), .go(go), .trig(trig),
    .flag_n(flag_n), .charge_request(charge_request), .flash_trigger(flash_trigger));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start;
    go <= 1'b0;
    cyc(8);
    go <= 1'b1;
    cyc(14);
    chk(primary_switch, 1'b1);
    chk(flag_oe, 1'b0);
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    chk(primary_switch, 1'b0);
    chk(flag_oe, 1'b0);
    rst <= 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      {psh, psa} <= rows[i][5:4];
      start();
      {lo, hi, an} <= rows[i][3:1];
      cyc(6);
      chk(primary_switch, rows[i][0]);
      {lo, hi, an} <= 3'h0;
      $display("peak row %0d done", i);
    end
    zero <= 1'b1;
    cyc(6);
    chk(primary_switch, 1'b1);
    zero <= 1'b0;
    go <= 1'b0;
    cyc(6);
    chk(primary_switch, 1'b0);
    chk(charge_enable_latch, 1'b0);
    $display("zero and stop test done");
    start();
    {psh, psa, lo} <= 3'h1;
    cyc(6);
    {lo, full} <= 2'h1;
    cyc(12);
    chk(charge_enable_latch, 1'b0);
    chk(flag_n, 1'b0);
    full <= 1'b0;
    cyc(30);
    chk(charge_enable_latch, 1'b0);
    chk(flag_oe, 1'b1);
    go <= 1'b0;
    cyc(6);
    chk(flag_oe, 1'b0);
    $display("full test done");
    start();
    ov <= 1'b1;
    cyc(6);
    chk(charge_enable_latch, 1'b0);
    {ov, full} <= 2'h1;
    cyc(30);
    chk(flag_oe, 1'b0);
    cyc(40);
    chk(charge_request, 1'b0);
    full <= 1'b0;
    $display("fault test done");
    foreach (gates[i]) begin
      {go, trig} <= gates[i][2:1];
      cyc(10);
      chk(gate_drive_out, gates[i][0]);
    end
    $display("gate test done");
    ce <= 1'b0;
    trig <= 1'b1;
    cyc(10);
    chk(gate_drive_out, 1'b0);
    ce <= 1'b1;
    cyc(10);
    chk(gate_drive_out, 1'b1);
    $display("clock enable test done");
    close_out();
  end
  initial begin
    cyc(3000);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
